//--- mecs_pkg.sv
`default_nettype none
package mecs_pkg;

  // register byte offsets
  localparam logic [7:0] MECS_OFS_COUNT_LOW = 8'h30;
  localparam logic [7:0] MECS_OFS_TAP_ORIENT = 8'h31;
  localparam logic [7:0] MECS_OFS_TAP_TIMING = 8'h32;
  localparam logic [7:0] MECS_OFS_WAKE_THS = 8'h33;
  localparam logic [7:0] MECS_OFS_WAKE_SLEEP = 8'h34;
  localparam logic [7:0] MECS_OFS_FALL_CFG = 8'h35;
  localparam logic [7:0] MECS_OFS_STATUS_COPY = 8'h36;

  // values after reset of the writable registers, and the value read at unmapped offsets
  localparam logic [7:0] MECS_RST_TAP_ORIENT = 8'h00;
  localparam logic [7:0] MECS_RST_TAP_TIMING = 8'h00;
  localparam logic [7:0] MECS_RST_WAKE_THS = 8'h00;
  localparam logic [7:0] MECS_RST_WAKE_SLEEP = 8'h00;
  localparam logic [7:0] MECS_RST_FALL_CFG = 8'h00;
  localparam logic [7:0] MECS_RD_UNMAPPED = 8'h00;

  // field positions
  localparam int MECS_POS_ORIENT_EN = 7;
  localparam int MECS_POS_ORIENT_THS = 5;
  localparam int MECS_POS_GAP = 4;
  localparam int MECS_POS_QUIET = 2;
  localparam int MECS_POS_TAP_MODE = 7;
  localparam int MECS_POS_SLEEP_ON = 6;
  localparam int MECS_POS_FALL_TOP = 7;
  localparam int MECS_POS_WAKE_DUR = 5;
  localparam int MECS_POS_ROUTE = 4;
  localparam int MECS_POS_FALL_LOW = 3;

  // output-data-rate periods per field count
  localparam int MECS_GAP_ODR = 32;
  localparam int MECS_QUIET_ODR = 4;
  localparam int MECS_SHOCK_ODR = 8;
  localparam int MECS_SLEEP_ODR = 512;

  // status copy bit positions, msb first
  localparam int MECS_ST_OVR = 7;
  localparam int MECS_ST_WAKE = 6;
  localparam int MECS_ST_SLEEP = 5;
  localparam int MECS_ST_DTAP = 4;
  localparam int MECS_ST_STAP = 3;
  localparam int MECS_ST_ORIENT = 2;
  localparam int MECS_ST_FALL = 1;
  localparam int MECS_ST_SAMPLE_READY_FLAG = 0;

  // orientation threshold in degrees
  function automatic logic [6:0] mecs_orient_deg(input logic [1:0] code);
    case (code)
      2'h0:    mecs_orient_deg = 7'h50;
      2'h1:    mecs_orient_deg = 7'h46;
      2'h2:    mecs_orient_deg = 7'h3C;
      default: mecs_orient_deg = 7'h32;
    endcase
  endfunction : mecs_orient_deg

  // free-fall threshold in 31.25 mg steps
  function automatic logic [4:0] mecs_fall_lsb(input logic [2:0] code);
    case (code)
      3'h0:    mecs_fall_lsb = 5'h05;
      3'h1:    mecs_fall_lsb = 5'h07;
      3'h2:    mecs_fall_lsb = 5'h08;
      3'h3:    mecs_fall_lsb = 5'h0A;
      3'h4:    mecs_fall_lsb = 5'h0B;
      3'h5:    mecs_fall_lsb = 5'h0D;
      3'h6:    mecs_fall_lsb = 5'h0F;
      default: mecs_fall_lsb = 5'h10;
    endcase
  endfunction : mecs_fall_lsb

endpackage : mecs_pkg
`default_nettype wire

//--- mecs_regs.sv
// The plain strobed port was chosen for this implementation.
`default_nettype none
// How it works
// - unread count: nine bits, low byte read at 0x30, top bit on its own output
// - orientation enable gates position detection
// - orientation threshold code maps to degrees
// - tap threshold five bits, FS/32 steps
// - double-tap gap counts 32 rate periods
// - quiet window counts 4 rate periods
// - shock limit counts 8 rate periods
// - tap mode: 0 single, 1 double
// - sleep enable bit gates inactivity detection
// - wake threshold six bits, FS/64 steps
// - fall duration: top bit plus five
// - wake duration two bits, rate periods
// - route fifo flag to first irq pad
// - sleep on the tick after duration times 512 periods
// - fall threshold code decoded to steps
// - read-only status copy, fixed bit order
// - overrun when full and sample overwritten
// - data ready when new xyz available
// - orientation flag on position change
// - event flags follow detected events
module mecs_regs
  import mecs_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              mclk_i,
  input  wire logic              rst_b_i,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [7:0]        reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic [7:0]             reg_rdata_o,
  // state from the fifo and the detection engine
  input  wire logic [8:0]        fifo_unread_count_i,
  input  wire logic              fifo_full_i,
  input  wire logic              fifo_overwrite_i,
  input  wire logic              fifo_level_flag_i,
  input  wire logic              xyz_new_i,
  input  wire logic              odr_tick_i,
  input  wire logic              motion_i,
  input  wire logic              wake_event_i,
  input  wire logic              single_tap_event_i,
  input  wire logic              double_tap_event_i,
  input  wire logic              position_change_i,
  input  wire logic              fall_event_i,
  // decoded configuration for the engine
  output logic                   orientation_enable_o,
  output logic [6:0]             orientation_threshold_deg_o,
  output logic [4:0]             tap_threshold_o,
  output logic                   double_tap_mode_o,
  output logic [8:0]             double_tap_gap_odr_o,
  output logic [3:0]             quiet_window_odr_o,
  output logic [4:0]             shock_limit_odr_o,
  output logic                   sleep_enable_o,
  output logic [5:0]             wake_threshold_o,
  output logic [5:0]             fall_duration_odr_o,
  output logic [1:0]             wake_duration_odr_o,
  output logic [12:0]            inactivity_duration_odr_o,
  output logic [4:0]             fall_threshold_lsb_o,
  // status and pads
  output logic                   unread_count_top_bit_o,
  output logic                   sleep_state_o,
  output logic [7:0]             event_status_o,
  output logic                   irq_pad_one_o
);

  // reset release: async assert, two-flop release
  logic       rst_meta_q;              // first release stage
  logic       rst_sync_q;              // released reset used below
  logic       rst_n;                   // local alias

  // writable configuration registers
  logic [7:0] tap_orient_threshold_q;  // 0x31
  logic [7:0] tap_timing_windows_q;    // 0x32
  logic [7:0] wake_threshold_cfg_q;    // 0x33
  logic [7:0] wake_sleep_duration_cfg_q; // 0x34
  logic [7:0] fall_detect_cfg_q;       // 0x35

  // read path and status
  logic [7:0] rdata_q;                 // read data, one cycle late
  logic [7:0] rdata_d;                 // selected read value
  logic [7:0] status_q;                // registered status copy
  logic [7:0] status_d;                // next status copy
  logic [8:0] count_q;                 // registered unread count
  logic       irq_q;                   // registered pad drive

  // inactivity timer, counts rate periods
  logic [12:0] idle_cnt_q;             // periods without motion
  logic [12:0] idle_cnt_d;             // next timer value
  logic        sleep_q;                // sleep state
  logic        sleep_d;                // next sleep state

  // write decode
  logic        wr_tap_orient;          // write to 0x31
  logic        wr_tap_timing;          // write to 0x32
  logic        wr_wake_ths;            // write to 0x33
  logic        wr_wake_sleep;          // write to 0x34
  logic        wr_fall_cfg;            // write to 0x35

  // decoded fields
  logic        orient_en;              // orientation enable
  logic        tap_mode;               // double-tap mode
  logic        sleep_on;               // sleep enable
  logic [3:0]  gap_field;              // double-tap gap
  logic [1:0]  quiet_field;            // quiet window
  logic [1:0]  shock_field;            // shock limit
  logic [3:0]  idle_field;             // inactivity duration
  logic [12:0] idle_limit;             // inactivity in periods

  // reset synchroniser; the first stage feeds only the second
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign rst_n = rst_sync_q;

  // address decode for writes; read-only offsets ignore writes
  assign wr_tap_orient = reg_wr_i
    && (reg_addr_i == ADDR_W'(MECS_OFS_TAP_ORIENT));
  assign wr_tap_timing = reg_wr_i
    && (reg_addr_i == ADDR_W'(MECS_OFS_TAP_TIMING));
  assign wr_wake_ths   = reg_wr_i
    && (reg_addr_i == ADDR_W'(MECS_OFS_WAKE_THS));
  assign wr_wake_sleep = reg_wr_i
    && (reg_addr_i == ADDR_W'(MECS_OFS_WAKE_SLEEP));
  assign wr_fall_cfg   = reg_wr_i
    && (reg_addr_i == ADDR_W'(MECS_OFS_FALL_CFG));

  // configuration storage
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      tap_orient_threshold_q    <= MECS_RST_TAP_ORIENT;
      tap_timing_windows_q      <= MECS_RST_TAP_TIMING;
      wake_threshold_cfg_q      <= MECS_RST_WAKE_THS;
      wake_sleep_duration_cfg_q <= MECS_RST_WAKE_SLEEP;
      fall_detect_cfg_q         <= MECS_RST_FALL_CFG;
    end else begin
      if (wr_tap_orient) begin
        tap_orient_threshold_q <= reg_wdata_i;
      end
      if (wr_tap_timing) begin
        tap_timing_windows_q <= reg_wdata_i;
      end
      if (wr_wake_ths) begin
        wake_threshold_cfg_q <= reg_wdata_i;
      end
      if (wr_wake_sleep) begin
        wake_sleep_duration_cfg_q <= reg_wdata_i;
      end
      if (wr_fall_cfg) begin
        fall_detect_cfg_q <= reg_wdata_i;
      end
    end
  end

  // field extraction
  assign orient_en   = tap_orient_threshold_q[MECS_POS_ORIENT_EN];
  assign tap_mode    = wake_threshold_cfg_q[MECS_POS_TAP_MODE];
  assign sleep_on    = wake_threshold_cfg_q[MECS_POS_SLEEP_ON];
  assign gap_field   = tap_timing_windows_q[MECS_POS_GAP +: 4];
  assign quiet_field = tap_timing_windows_q[MECS_POS_QUIET +: 2];
  assign shock_field = tap_timing_windows_q[1:0];
  assign idle_field  = wake_sleep_duration_cfg_q[3:0];

  // durations scaled to rate periods; the engine steps on odr_tick_i,
  // so a new data rate rescales every window without a rewrite
  assign double_tap_gap_odr_o = 9'(gap_field * MECS_GAP_ODR);
  assign quiet_window_odr_o = 4'(quiet_field * MECS_QUIET_ODR);
  assign shock_limit_odr_o = 5'(shock_field * MECS_SHOCK_ODR);
  assign idle_limit = 13'(idle_field * MECS_SLEEP_ODR);
  assign inactivity_duration_odr_o = idle_limit;
  assign wake_duration_odr_o =
    wake_sleep_duration_cfg_q[MECS_POS_WAKE_DUR +: 2];
  assign fall_duration_odr_o = {
    wake_sleep_duration_cfg_q[MECS_POS_FALL_TOP],
    fall_detect_cfg_q[MECS_POS_FALL_LOW +: 5]};

  // thresholds and modes for the engine
  assign orientation_enable_o = orient_en;
  assign orientation_threshold_deg_o = mecs_orient_deg(
    tap_orient_threshold_q[MECS_POS_ORIENT_THS +: 2]);
  assign tap_threshold_o = tap_orient_threshold_q[4:0];
  assign double_tap_mode_o = tap_mode;
  assign sleep_enable_o = sleep_on;
  assign wake_threshold_o = wake_threshold_cfg_q[5:0];
  assign fall_threshold_lsb_o = mecs_fall_lsb(fall_detect_cfg_q[2:0]);

  // inactivity timer: restart on motion or when disabled
  always_comb begin
    idle_cnt_d = idle_cnt_q;
    sleep_d    = sleep_q;
    if (!sleep_on || motion_i) begin
      idle_cnt_d = 13'h0000;
      sleep_d    = 1'b0;
    end else if (odr_tick_i) begin
      if (idle_cnt_q >= idle_limit) begin
        sleep_d = 1'b1;
      end else begin
        idle_cnt_d = idle_cnt_q + 13'h0001;
      end
    end
  end

  // timer state
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      idle_cnt_q <= 13'h0000;
      sleep_q    <= 1'b0;
    end else begin
      idle_cnt_q <= idle_cnt_d;
      sleep_q    <= sleep_d;
    end
  end

  // status copy; gated by mode so a disabled event never shows
  always_comb begin
    status_d = 8'h00;
    status_d[MECS_ST_OVR] = fifo_full_i && fifo_overwrite_i;
    status_d[MECS_ST_WAKE] = wake_event_i;
    status_d[MECS_ST_SLEEP] = sleep_q;
    status_d[MECS_ST_DTAP] = tap_mode && double_tap_event_i;
    status_d[MECS_ST_STAP] = !tap_mode && single_tap_event_i;
    status_d[MECS_ST_ORIENT] = orient_en && position_change_i;
    status_d[MECS_ST_FALL] = fall_event_i;
    status_d[MECS_ST_SAMPLE_READY_FLAG] = xyz_new_i;
  end

  // status, count and pad registers
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= 8'h00;
      count_q  <= 9'h000;
      irq_q    <= 1'b0;
    end else begin
      status_q <= status_d;
      count_q  <= fifo_unread_count_i;
      irq_q    <= fifo_level_flag_i &&
                  wake_sleep_duration_cfg_q[MECS_POS_ROUTE];
    end
  end

  // read mux; unmapped offsets read as zero
  always_comb begin
    case (reg_addr_i)
      ADDR_W'(MECS_OFS_COUNT_LOW):   rdata_d = count_q[7:0];
      ADDR_W'(MECS_OFS_TAP_ORIENT):  rdata_d = tap_orient_threshold_q;
      ADDR_W'(MECS_OFS_TAP_TIMING):  rdata_d = tap_timing_windows_q;
      ADDR_W'(MECS_OFS_WAKE_THS):    rdata_d = wake_threshold_cfg_q;
      ADDR_W'(MECS_OFS_WAKE_SLEEP):  rdata_d = wake_sleep_duration_cfg_q;
      ADDR_W'(MECS_OFS_FALL_CFG):    rdata_d = fall_detect_cfg_q;
      ADDR_W'(MECS_OFS_STATUS_COPY): rdata_d = status_q;
      default:                       rdata_d = MECS_RD_UNMAPPED;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else if (reg_rd_i) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata_o            = rdata_q;
  assign unread_count_top_bit_o = count_q[8];
  assign sleep_state_o          = sleep_q;
  assign event_status_o         = status_q;
  assign irq_pad_one_o          = irq_q;

endmodule : mecs_regs
`default_nettype wire

//--- mecs_regs_asserts.sv
`default_nettype none
module mecs_regs_chk
  import mecs_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic              mclk_i,
  input wire logic              rst_b_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0]        reg_wdata_i,
  input wire logic              reg_wr_i,
  input wire logic              reg_rd_i,
  input wire logic [7:0]        reg_rdata_o,
  input wire logic [8:0]        fifo_unread_count_i,
  input wire logic              fifo_full_i,
  input wire logic              fifo_overwrite_i,
  input wire logic              fifo_level_flag_i,
  input wire logic              odr_tick_i,
  input wire logic              motion_i,
  input wire logic              double_tap_event_i,
  input wire logic              double_tap_mode_o,
  input wire logic [6:0]        orientation_threshold_deg_o,
  input wire logic [8:0]        double_tap_gap_odr_o,
  input wire logic              sleep_enable_o,
  input wire logic [5:0]        fall_duration_odr_o,
  input wire logic [12:0]       inactivity_duration_odr_o,
  input wire logic              unread_count_top_bit_o,
  input wire logic              sleep_state_o,
  input wire logic [7:0]        event_status_o,
  input wire logic              irq_pad_one_o
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [2:0] up_q;     // edges since release of reset
  logic [7:0] sh_q [5]; // shadow of the five writable registers
  logic       live;     // design is past its own delayed release
  assign live = (up_q == 3'h5);

  // settle count: the design leaves reset two flops after the pin does
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) up_q <= 3'h0;
    else if (!live) up_q <= up_q + 3'h1;
  end

  // mirror accepted writes, so decodes can be judged against them
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) sh_q <= '{default: 8'h00};
    else if (reg_wr_i && reg_addr_i >= MECS_OFS_TAP_ORIENT
             && reg_addr_i <= MECS_OFS_FALL_CFG)
      sh_q[3'(reg_addr_i - MECS_OFS_TAP_ORIENT)] <= reg_wdata_i;
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  rd_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data not cleared");
  count_read_a: assert property (reg_rd_i && live
    && reg_addr_i == MECS_OFS_COUNT_LOW && $stable(fifo_unread_count_i)
    |=> reg_rdata_o == $past(fifo_unread_count_i[7:0]))
    else $error("count low byte wrong");
  count_top_a: assert property (live
    |=> unread_count_top_bit_o == $past(fifo_unread_count_i[8]))
    else $error("count top bit wrong");
  overrun_a: assert property (live |=> event_status_o[MECS_ST_OVR]
    == $past(fifo_full_i && fifo_overwrite_i))
    else $error("overrun flag wrong");
  dtap_gate_a: assert property (live |=> event_status_o[MECS_ST_DTAP]
    == $past(double_tap_event_i && double_tap_mode_o))
    else $error("double tap flag wrong");
  irq_route_a: assert property (live |=> irq_pad_one_o
    == $past(fifo_level_flag_i && sh_q[3][MECS_POS_ROUTE]))
    else $error("irq pad wrong");
  orient_deg_a: assert property (orientation_threshold_deg_o
    == 7'h50 - 7'h0A * 7'(sh_q[0][6:5]))
    else $error("orientation threshold wrong");
  gap_scale_a: assert property (double_tap_gap_odr_o
    == {sh_q[1][7:4], 5'h00})
    else $error("double tap gap wrong");
  inactivity_duration_a: assert property (inactivity_duration_odr_o
    == {sh_q[3][3:0], 9'h000})
    else $error("sleep duration wrong");
  fall_dur_a: assert property (fall_duration_odr_o
    == {sh_q[3][7], sh_q[4][7:3]})
    else $error("fall duration wrong");
  sleep_rise_a: assert property ($rose(sleep_state_o)
    |-> $past(odr_tick_i && sleep_enable_o && !motion_i))
    else $error("sleep entered without tick");
  sleep_clear_a: assert property (live && (motion_i || !sleep_enable_o)
    |=> !sleep_state_o)
    else $error("sleep not cleared");
endmodule : mecs_regs_chk
`default_nettype wire

//--- tb_motion_event_config_status_regs.sv
`default_nettype none
module tb_motion_event_config_status_regs
  import mecs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // stimulus, named after the ports it feeds
  logic        mclk_i = 1'b0, rst_b_i = 1'b0;
  logic [7:0]  reg_addr_i = 8'h00, reg_wdata_i = 8'h00;
  logic        reg_wr_i = 1'b0, reg_rd_i = 1'b0, odr_tick_i = 1'b0;
  logic [8:0]  fifo_unread_count_i = 9'h000;
  logic        fifo_full_i = 1'b0, fifo_overwrite_i = 1'b0;
  logic        fifo_level_flag_i = 1'b0, xyz_new_i = 1'b0;
  logic        motion_i = 1'b0, wake_event_i = 1'b0, fall_event_i = 1'b0;
  logic        single_tap_event_i = 1'b0, double_tap_event_i = 1'b0;
  logic        position_change_i = 1'b0;
  // observed outputs
  logic [7:0]  reg_rdata_o, event_status_o;
  logic        orientation_enable_o, double_tap_mode_o, sleep_enable_o;
  logic        unread_count_top_bit_o, sleep_state_o, irq_pad_one_o;
  logic [6:0]  orientation_threshold_deg_o;
  logic [4:0]  tap_threshold_o, shock_limit_odr_o, fall_threshold_lsb_o;
  logic [8:0]  double_tap_gap_odr_o;
  logic [3:0]  quiet_window_odr_o;
  logic [5:0]  wake_threshold_o, fall_duration_odr_o;
  logic [1:0]  wake_duration_odr_o;
  logic [12:0] inactivity_duration_odr_o;
  int          num_errors = 0, num_checks = 0, cycles = 0;

  mecs_regs dut (
    .mclk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .fifo_unread_count_i, .fifo_full_i, .fifo_overwrite_i,
    .fifo_level_flag_i, .xyz_new_i, .odr_tick_i, .motion_i, .wake_event_i,
    .single_tap_event_i, .double_tap_event_i, .position_change_i,
    .fall_event_i, .orientation_enable_o, .orientation_threshold_deg_o,
    .tap_threshold_o, .double_tap_mode_o, .double_tap_gap_odr_o,
    .quiet_window_odr_o, .shock_limit_odr_o, .sleep_enable_o,
    .wake_threshold_o, .fall_duration_odr_o, .wake_duration_odr_o,
    .inactivity_duration_odr_o, .fall_threshold_lsb_o,
    .unread_count_top_bit_o, .sleep_state_o, .event_status_o, .irq_pad_one_o
  );

  // 250 MHz clock
  initial begin
    forever #2 mclk_i = ~mclk_i;
  end

  task automatic check(input string nm, input logic [12:0] seen,
                       input logic [12:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask : check

  // one-cycle write strobe; entered just after a rising edge
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
    // let an edge pass so a following call never re-drives the strobe
    @(posedge mclk_i);
  endtask : wr_reg

  // read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1 check("read data", reg_rdata_o, exp);
    @(posedge mclk_i);
  endtask : rd_reg

  // rate ticks every other cycle, so timing is in ticks, not clocks
  task automatic ticks(input int n);
    repeat (n) begin
      odr_tick_i <= 1'b1;
      @(posedge mclk_i);
      odr_tick_i <= 1'b0;
      @(posedge mclk_i);
    end
    repeat (2) @(posedge mclk_i);
  endtask : ticks

  task automatic t_cfg;
    logic [7:0] v;
    logic [4:0] tab [8];
    tab = '{5'h05, 5'h07, 5'h08, 5'h0A, 5'h0B, 5'h0D, 5'h0F, 5'h10};
    for (int a = 8'h30; a <= 8'h37; a++) rd_reg(8'(a), 8'h00);
    for (int i = 0; i < 8; i++) begin
      v = {i[0], i[1:0], i[2:0], i[1:0]};
      for (int a = 8'h31; a <= 8'h35; a++) wr_reg(8'(a), v);
      for (int a = 8'h31; a <= 8'h35; a++) rd_reg(8'(a), v);
      check("orient en", orientation_enable_o, v[7]);
      check("orient deg", orientation_threshold_deg_o,
            7'h50 - 7'h0A * v[6:5]);
      check("tap thr", tap_threshold_o, v[4:0]);
      check("gap", double_tap_gap_odr_o, {v[7:4], 5'h00});
      check("quiet", quiet_window_odr_o, {v[3:2], 2'h0});
      check("shock", shock_limit_odr_o, {v[1:0], 3'h0});
      check("tap mode", double_tap_mode_o, v[7]);
      check("sleep en", sleep_enable_o, v[6]);
      check("wake thr", wake_threshold_o, v[5:0]);
      check("fall dur", fall_duration_odr_o, {v[7], v[7:3]});
      check("wake dur", wake_duration_odr_o, v[6:5]);
      check("inactivity_duration", inactivity_duration_odr_o, {v[3:0], 9'h000});
      check("fall thr", fall_threshold_lsb_o, tab[v[2:0]]);
    end
    wr_reg(MECS_OFS_COUNT_LOW, 8'h5A);
    wr_reg(MECS_OFS_STATUS_COPY, 8'h5A);
    wr_reg(8'h40, 8'h5A);
    rd_reg(MECS_OFS_COUNT_LOW, 8'h00);
    rd_reg(MECS_OFS_STATUS_COPY, 8'h00);
    rd_reg(8'h40, 8'h00);
    $display("test config done");
  endtask : t_cfg

  task automatic t_count;
    logic [8:0] n [4];
    n = '{9'h100, 9'h0FF, 9'h001, 9'h000};
    for (int k = 0; k < 4; k++) begin
      fifo_unread_count_i <= n[k];
      repeat (2) @(posedge mclk_i);
      rd_reg(MECS_OFS_COUNT_LOW, n[k][7:0]);
      check("count top", unread_count_top_bit_o, n[k][8]);
    end
    $display("test count done");
  endtask : t_count

  task automatic t_status;
    logic [7:0] e;
    logic [7:0] x;
    for (int m = 0; m < 2; m++) begin
      wr_reg(MECS_OFS_TAP_ORIENT, {m[0], 7'h00});
      wr_reg(MECS_OFS_WAKE_THS, {m[0], 7'h00});
      for (int j = 0; j < 9; j++) begin
        e = (j == 8) ? 8'hC0 : 8'(1 << j);
        {fifo_full_i, fifo_overwrite_i, wake_event_i, double_tap_event_i,
         single_tap_event_i, position_change_i, fall_event_i, xyz_new_i} <= e;
        x = {e[7] & e[6], e[5], 1'b0, e[4] & m[0], e[3] & ~m[0],
             e[2] & m[0], e[1], e[0]};
        repeat (2) @(posedge mclk_i);
        rd_reg(MECS_OFS_STATUS_COPY, x);
        check("status", event_status_o, x);
      end
    end
    {fifo_full_i, fifo_overwrite_i, xyz_new_i} <= 3'h0;
    $display("test status done");
  endtask : t_status

  task automatic t_route_sleep;
    for (int r = 0; r < 2; r++) begin
      wr_reg(MECS_OFS_WAKE_SLEEP, {3'h0, r[0], 4'h0});
      fifo_level_flag_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      check("irq pad", irq_pad_one_o, r[0]);
      fifo_level_flag_i <= 1'b0;
      repeat (3) @(posedge mclk_i);
      check("irq pad", irq_pad_one_o, 1'b0);
    end
    wr_reg(MECS_OFS_WAKE_THS, 8'h40);
    wr_reg(MECS_OFS_WAKE_SLEEP, 8'h00);
    repeat (3) @(posedge mclk_i);
    check("sleep", sleep_state_o, 1'b0);
    ticks(1);
    check("sleep", sleep_state_o, 1'b1);
    rd_reg(MECS_OFS_STATUS_COPY, 8'h20);
    motion_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    check("sleep", sleep_state_o, 1'b0);
    motion_i <= 1'b0;
    wr_reg(MECS_OFS_WAKE_SLEEP, 8'h01);
    ticks(500);
    check("sleep", sleep_state_o, 1'b0);
    ticks(20);
    check("sleep", sleep_state_o, 1'b1);
    wr_reg(MECS_OFS_WAKE_THS, 8'h00);
    repeat (2) @(posedge mclk_i);
    check("sleep", sleep_state_o, 1'b0);
    $display("test route and sleep done");
  endtask : t_route_sleep

  task automatic close_out;
    $display("checks %0d, mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out

  // hang guard: the sequence needs well under 5000 cycles
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      close_out();
    end
  end

  initial begin
    repeat (10) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    t_cfg();
    t_count();
    t_status();
    t_route_sleep();
    close_out();
  end
endmodule : tb_motion_event_config_status_regs

bind mecs_regs mecs_regs_chk #(.ADDR_W(ADDR_W)) u_chk (
  .mclk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
  .reg_rdata_o, .fifo_unread_count_i, .fifo_full_i, .fifo_overwrite_i,
  .fifo_level_flag_i, .odr_tick_i, .motion_i, .double_tap_event_i,
  .double_tap_mode_o, .orientation_threshold_deg_o, .double_tap_gap_odr_o,
  .sleep_enable_o, .fall_duration_odr_o, .inactivity_duration_odr_o,
  .unread_count_top_bit_o, .sleep_state_o, .event_status_o, .irq_pad_one_o
);
`default_nettype wire
